// [pkg/dmr_params.svh]
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH

// register offsets inside one controller window
`define DMR_OFF_FLAGS 10'h000
`define DMR_OFF_CLEAR 10'h004
`define DMR_OFF_CH_CTL 10'h008
`define DMR_CH_STRIDE 10'h014
// per-channel register offsets, relative to that channel's control register
`define DMR_REL_CNT 10'h004
`define DMR_REL_PADDR 10'h008
`define DMR_REL_MADDR 10'h00c
// controller base addresses; only bits 31:10 are decoded
`define DMR_BASE_FIRST 32'h4002_0000
`define DMR_BASE_SECOND 32'h4002_0400
`define DMR_WIN_LSB 10
// channel counts of the two instances
`define DMR_MAX_CH 7
`define DMR_SMALL_CH 5
// control field positions
`define DMR_CTL_EN 0
`define DMR_CTL_FULL_IE 1
`define DMR_CTL_HALF_IE 2
`define DMR_CTL_ERR_IE 3
`define DMR_CTL_DIR 4
`define DMR_CTL_CIRC 5
`define DMR_CTL_PINC 6
`define DMR_CTL_MINC 7
`define DMR_CTL_PW_LSB 8
`define DMR_CTL_MW_LSB 10
`define DMR_CTL_PRIORITY_LEVEL_LSB 12
`define DMR_CTL_M2M 14
`define DMR_CTL_W 15
// field groups: locked while enabled, always writable
`define DMR_CTL_LOCK_MASK 15'h7ff0
`define DMR_CTL_OPEN_MASK 15'h000f
// flag positions inside one four-bit channel group
`define DMR_FLG_ANY 0
`define DMR_FLG_FULL 1
`define DMR_FLG_HALF 2
`define DMR_FLG_ERR 3
`define DMR_FLG_GROUP 4
// reset values
`define DMR_CTL_RST 15'h0000
`define DMR_CNT_RST 16'h0000
`define DMR_ADDR_RST 32'h0000_0000
`define DMR_FLAGS_RST 32'h0000_0000

`endif

// [pkg/dmr_pkg.sv]
package dmr_pkg;
    // data width codes of either side
    typedef enum logic [1:0] {
        DMR_W8 = 2'b00,
        DMR_W16 = 2'b01,
        DMR_W32 = 2'b10,
        DMR_WRSV = 2'b11
    } dmr_width_t;
    // arbitration priority codes
    typedef enum logic [1:0] {
        DMR_PRI_LOW = 2'b00,
        DMR_PRI_MED = 2'b01,
        DMR_PRI_HIGH = 2'b10,
        DMR_PRI_ULTRA = 2'b11
    } dmr_priority_level_t;
endpackage

// [hdl/dmr_chan.sv]
`timescale 1ns/1ps
`include "dmr_params.svh"
module dmr_chan
    import dmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_ctl,
    input wire logic wr_cnt,
    input wire logic wr_paddr,
    input wire logic wr_maddr,
    input wire logic [31:0] wdata,
    input wire logic xfer_done,
    output logic [`DMR_CTL_W-1:0] ctl_r,
    output logic [15:0] cnt_r,
    output logic [31:0] pbase_r,
    output logic [31:0] mbase_r,
    output logic [31:0] pcur_r,
    output logic [31:0] mcur_r,
    output logic active,
    output logic half_evt,
    output logic full_evt
);
    ////////////////////////////////////////////////////////////////
    logic [15:0] reload_r; // programmed count, kept for circular reload
    logic enabled;
    logic step; // one transfer completed on this channel
    logic [15:0] cnt_dec;
    logic [`DMR_CTL_W-1:0] ctl_nxt;
    logic [31:0] pstep;
    logic [31:0] mstep;

    // stride per transfer from the width code; reserved code steps as a word
    function automatic logic [31:0] width_step(input logic [1:0] code);
        case (dmr_width_t'(code))
            DMR_W8: width_step = 32'h0000_0001;
            DMR_W16: width_step = 32'h0000_0002;
            default: width_step = 32'h0000_0004;
        endcase
    endfunction

    assign enabled = ctl_r[`DMR_CTL_EN];
    assign active = enabled && (cnt_r != 16'h0000);
    assign step = xfer_done && active;
    assign cnt_dec = cnt_r - 16'h0001;
    assign half_evt = step && (cnt_dec == (reload_r >> 1));
    assign full_evt = step && (cnt_dec == 16'h0000);
    assign pstep = ctl_r[`DMR_CTL_PINC] ? width_step(ctl_r[`DMR_CTL_PW_LSB +: 2]) : 32'h0;
    assign mstep = ctl_r[`DMR_CTL_MINC] ? width_step(ctl_r[`DMR_CTL_MW_LSB +: 2]) : 32'h0;
    // locked fields keep their value while the channel runs
    assign ctl_nxt = enabled ? ((ctl_r & `DMR_CTL_LOCK_MASK) | (wdata[`DMR_CTL_W-1:0] & `DMR_CTL_OPEN_MASK))
        : wdata[`DMR_CTL_W-1:0];

    ////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_r <= `DMR_CTL_RST;
        else if (wr_ctl)
            ctl_r <= ctl_nxt;
    end

    // base registers, writable only while disabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reload_r <= `DMR_CNT_RST;
            pbase_r <= `DMR_ADDR_RST;
            mbase_r <= `DMR_ADDR_RST;
        end
        else if (!enabled)
        begin
            if (wr_cnt)
                reload_r <= wdata[15:0];
            if (wr_paddr)
                pbase_r <= wdata;
            if (wr_maddr)
                mbase_r <= wdata;
        end
    end

    // live count and addresses; a disabled channel tracks its bases
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= `DMR_CNT_RST;
            pcur_r <= `DMR_ADDR_RST;
            mcur_r <= `DMR_ADDR_RST;
        end
        else if (!enabled)
        begin
            if (wr_cnt)
                cnt_r <= wdata[15:0];
            pcur_r <= wr_paddr ? wdata : pbase_r;
            mcur_r <= wr_maddr ? wdata : mbase_r;
        end
        else if (full_evt && ctl_r[`DMR_CTL_CIRC])
        begin
            cnt_r <= reload_r;
            pcur_r <= pbase_r;
            mcur_r <= mbase_r;
        end
        else if (step)
        begin
            cnt_r <= cnt_dec;
            pcur_r <= pcur_r + pstep;
            mcur_r <= mcur_r + mstep;
        end
    end
endmodule // dmr_chan

// [hdl/dmr_regs.sv]
`timescale 1ns/1ps
`include "dmr_params.svh"
module dmr_regs
    import dmr_pkg::*;
#(
    parameter int NUM_CH = `DMR_MAX_CH,
    parameter logic [31:0] BASE_ADDR = `DMR_BASE_FIRST
)
(
    input wire logic clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // datapath events, same clock, one-cycle pulses
    input wire logic [`DMR_MAX_CH-1:0] xfer_done,
    input wire logic [`DMR_MAX_CH-1:0] xfer_error,
    // per-channel status and configuration to the datapath
    output logic [`DMR_MAX_CH-1:0] ch_active,
    output logic [`DMR_MAX_CH-1:0] ch_irq,
    output logic [`DMR_MAX_CH-1:0] ch_mem2mem,
    output logic [`DMR_MAX_CH-1:0] ch_dir,
    output logic [2*`DMR_MAX_CH-1:0] ch_priority,
    output logic [2*`DMR_MAX_CH-1:0] ch_mem_width,
    output logic [2*`DMR_MAX_CH-1:0] ch_periph_width,
    output logic [32*`DMR_MAX_CH-1:0] ch_mem_addr,
    output logic [32*`DMR_MAX_CH-1:0] ch_periph_addr
);
    // register map, byte offsets in the window:
    // 0x00 flags, read only
    // 0x04 clear, a one clears, a zero does nothing
    // 0x08 control, 0x0c count
    // 0x10 peripheral base, 0x14 memory base
    // channel registers repeat every 0x14 bytes
    // other offsets read zero, drop writes
    // count and bases refuse writes while enabled:
    // one more write to stop a channel, but the
    // datapath never sees them move mid-run
    // only haddr 31:10 is compared
    // instances differ in BASE_ADDR and NUM_CH
    // smaller instance: channels 0 to 4 only
    // control: 0 enable, 3:1 irq enables
    // 4 direction, 5 circular, 6 and 7 steps
    // 9:8 and 11:10 widths, 13:12 priority
    // 14 memory to memory, 31:15 read zero
    // bits 14:4 hold while enabled
    // width code 11 is stored as written
    // flag group, low bit first: any, full,
    // half, error
    ////////////////////////////////////////////////////////////////
    // reset release
    ////////////////////////////////////////////////////////////////
    // pin reset clears at once, its rise is retimed
    // so every flop leaves reset on the same edge
    // limitation: first address phase waits two
    // edges after the rise
    // a short glitch still gives a full reset
    // stage 0 feeds stage 1 and nothing else
    logic [1:0] rst_sync_r; // release synchroniser, stage 0 feeds stage 1 only
    logic rst_n; // synchronised reset used everywhere else

    // assert at once, release two edges later
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////
    // bus front end
    ////////////////////////////////////////////////////////////////
    // one slave, single word transfers only
    // write: no wait state, lands at data end
    // read: one wait state to load the data flop
    // trade-off: a cycle per read buys a
    // registered read mux and a fresh view of
    // a write just ahead
    // hsize not decoded; narrow writes act as words
    // response always okay, unmapped too
    // next address may overlap a write data phase
    // hreadyout is low only in a read wait
    logic [31:0] addr_r; // captured address phase
    logic wr_pend_r; // write data phase in progress
    logic rd_wait_r; // first read data cycle, bus stalled
    logic [31:0] rdata_r; // registered read data
    logic addr_take; // address phase accepted
    logic wr_go; // write data valid this cycle
    logic win_hit; // address falls in this controller's window
    logic [9:0] off; // offset inside the window
    logic [31:0] rd_mux; // selected read value

    assign addr_take = hsel && htrans[1] && hready;
    assign wr_go = wr_pend_r;
    assign win_hit = (addr_r[31:`DMR_WIN_LSB] == BASE_ADDR[31:`DMR_WIN_LSB]);
    assign off = addr_r[9:0];
    // reads stall one cycle so a write just ahead is always seen
    assign hreadyout = !rd_wait_r;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    // address phase capture; hsize unused, only whole words are mapped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_r <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
        end
        else
        begin
            if (addr_take)
                addr_r <= haddr;
            wr_pend_r <= addr_take && hwrite;
            rd_wait_r <= addr_take && !hwrite;
        end
    end

    // read data latched at the end of the stall cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= 32'h0000_0000;
        else if (rd_wait_r)
            rdata_r <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////
    // flag and clear registers
    ////////////////////////////////////////////////////////////////
    // flags live in the slices below; this word
    // only gathers them for the bus
    // the clear register has no storage, its
    // write is a one-cycle strobe
    // writes to the flag word are dropped
    // event and clear together: event wins
    logic sel_flags;
    logic sel_clear;
    logic clr_go; // write to the clear register
    logic [31:0] flags; // assembled flag register view
    logic [31:0] ch_rd [0:`DMR_MAX_CH]; // per-channel read contribution chain

    assign sel_flags = win_hit && (off == `DMR_OFF_FLAGS);
    assign sel_clear = win_hit && (off == `DMR_OFF_CLEAR);
    assign clr_go = wr_go && sel_clear;
    // clear register reads as zero, it holds nothing
    assign ch_rd[0] = sel_flags ? flags : 32'h0000_0000;
    assign rd_mux = ch_rd[`DMR_MAX_CH];

    ////////////////////////////////////////////////////////////////
    // per-channel slices
    ////////////////////////////////////////////////////////////////
    // one slice per channel position
    // positions at or above NUM_CH build no storage
    // and tie every output low, so a stray write
    // or event cannot wake them
    // readback is an OR chain; one select at most
    // is high, so no priority is needed
    // packed outputs: 1 bit at i, 2 bits at 2*i,
    // 32 bits at 32*i
    // slices share the decode, none talks to another
    // at most 7 channels; NUM_CH may not exceed it
    genvar gi;
    generate
        for (gi = 0; gi < `DMR_MAX_CH; gi++)
        begin : g_ch
            localparam logic [9:0] CH_OFF = 10'(`DMR_OFF_CH_CTL + gi * `DMR_CH_STRIDE);
            localparam int FB = gi * `DMR_FLG_GROUP; // lowest flag bit of this group

            if (gi < NUM_CH)
            begin : g_on
                logic sel_ctl;
                logic sel_cnt;
                logic sel_pa;
                logic sel_ma;
                logic [`DMR_CTL_W-1:0] ctl;
                logic [15:0] cnt;
                logic [31:0] pbase;
                logic [31:0] mbase;
                logic [31:0] pcur;
                logic [31:0] mcur;
                logic half_evt;
                logic full_evt;
                logic active;
                logic err_r; // sticky error flag
                logic half_r; // sticky half flag
                logic full_r; // sticky full flag
                logic clr_all; // all-flags clear of this group
                logic clr_err;
                logic clr_half;
                logic clr_full;
                logic [31:0] own_rd;

                // selects from the captured address,
                // steady through the data phase
                assign sel_ctl = win_hit && (off == CH_OFF);
                assign sel_cnt = win_hit && (off == 10'(CH_OFF + `DMR_REL_CNT));
                assign sel_pa = win_hit && (off == 10'(CH_OFF + `DMR_REL_PADDR));
                assign sel_ma = win_hit && (off == 10'(CH_OFF + `DMR_REL_MADDR));

                // channel registers, counter and address walker
                dmr_chan u_chan (
                    .clk(clk),
                    .rst_n(rst_n),
                    .wr_ctl(wr_go && sel_ctl),
                    .wr_cnt(wr_go && sel_cnt),
                    .wr_paddr(wr_go && sel_pa),
                    .wr_maddr(wr_go && sel_ma),
                    .wdata(hwdata),
                    .xfer_done(xfer_done[gi]),
                    .ctl_r(ctl),
                    .cnt_r(cnt),
                    .pbase_r(pbase),
                    .mbase_r(mbase),
                    .pcur_r(pcur),
                    .mcur_r(mcur),
                    .active(active),
                    .half_evt(half_evt),
                    .full_evt(full_evt)
                );

                // clear strobes; the group clear hits all three
                // the any bit has no storage of its own
                assign clr_all = clr_go && hwdata[FB + `DMR_FLG_ANY];
                assign clr_err = clr_all || (clr_go && hwdata[FB + `DMR_FLG_ERR]);
                assign clr_half = clr_all || (clr_go && hwdata[FB + `DMR_FLG_HALF]);
                assign clr_full = clr_all || (clr_go && hwdata[FB + `DMR_FLG_FULL]);

                // sticky flags; an event in the clear cycle wins
                // losing an event would hide a transfer;
                // a repeated clear costs one write
                // errors count only while enabled
                // half mark: count left equals half the
                // programmed count, rounded down
                always_ff @(posedge clk or negedge rst_n)
                begin
                    if (!rst_n)
                    begin
                        err_r <= 1'b0;
                        half_r <= 1'b0;
                        full_r <= 1'b0;
                    end
                    else
                    begin
                        err_r <= (xfer_error[gi] && ctl[`DMR_CTL_EN]) || (err_r && !clr_err);
                        half_r <= half_evt || (half_r && !clr_half);
                        full_r <= full_evt || (full_r && !clr_full);
                    end
                end

                // flag group, any-event bit derived from the other three
                // pure OR, so it never disagrees
                assign flags[FB + `DMR_FLG_ERR] = err_r;
                assign flags[FB + `DMR_FLG_HALF] = half_r;
                assign flags[FB + `DMR_FLG_FULL] = full_r;
                assign flags[FB + `DMR_FLG_ANY] = err_r || half_r || full_r;

                // readback, upper bits zero
                // count reads live, bases read as written
                assign own_rd = sel_ctl ? {17'h0, ctl} :
                    sel_cnt ? {16'h0, cnt} :
                    sel_pa ? pbase :
                    sel_ma ? mbase : 32'h0000_0000;
                assign ch_rd[gi + 1] = ch_rd[gi] | own_rd;

                // configuration out to the datapath
                // current addresses go out, not bases
                // reserved width codes pass unchanged
                assign ch_active[gi] = active;
                assign ch_mem2mem[gi] = ctl[`DMR_CTL_M2M];
                assign ch_dir[gi] = ctl[`DMR_CTL_DIR];
                assign ch_priority[2*gi +: 2] = ctl[`DMR_CTL_PRIORITY_LEVEL_LSB +: 2];
                assign ch_mem_width[2*gi +: 2] = ctl[`DMR_CTL_MW_LSB +: 2];
                assign ch_periph_width[2*gi +: 2] = ctl[`DMR_CTL_PW_LSB +: 2];
                assign ch_mem_addr[32*gi +: 32] = mcur;
                assign ch_periph_addr[32*gi +: 32] = pcur;
                // enabled events raise the channel's own interrupt
                // a level: stays up until cleared or
                // until the enable is dropped
                assign ch_irq[gi] = (err_r && ctl[`DMR_CTL_ERR_IE]) ||
                    (half_r && ctl[`DMR_CTL_HALF_IE]) ||
                    (full_r && ctl[`DMR_CTL_FULL_IE]);
            end
            else
            begin : g_off
                // absent channel: flags, clears and control are inert
                // reads fall through, writes land nowhere
                assign flags[FB +: `DMR_FLG_GROUP] = 4'h0;
                assign ch_rd[gi + 1] = ch_rd[gi];
                assign ch_active[gi] = 1'b0;
                assign ch_irq[gi] = 1'b0;
                assign ch_mem2mem[gi] = 1'b0;
                assign ch_dir[gi] = 1'b0;
                assign ch_priority[2*gi +: 2] = 2'h0;
                assign ch_mem_width[2*gi +: 2] = 2'h0;
                assign ch_periph_width[2*gi +: 2] = 2'h0;
                assign ch_mem_addr[32*gi +: 32] = 32'h0000_0000;
                assign ch_periph_addr[32*gi +: 32] = 32'h0000_0000;
            end
        end
    endgenerate

    // top nibble has no channel behind it
    // constant, so synthesis drops the wiring
    // bits above the last channel group always read zero
    assign flags[31:`DMR_FLG_GROUP*`DMR_MAX_CH] = 4'h0;

endmodule // dmr_regs

// [testbench/dmr_regs_monitor.sv]
`timescale 1ns/1ps
`include "dmr_params.svh"
module dmr_regs_monitor
    import dmr_pkg::*;
#(
    parameter int NUM_CH = `DMR_MAX_CH
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [`DMR_MAX_CH-1:0] xfer_done,
    input wire logic [`DMR_MAX_CH-1:0] xfer_error,
    input wire logic [`DMR_MAX_CH-1:0] ch_active,
    input wire logic [`DMR_MAX_CH-1:0] ch_irq,
    input wire logic [`DMR_MAX_CH-1:0] ch_mem2mem,
    input wire logic [`DMR_MAX_CH-1:0] ch_dir,
    input wire logic [2*`DMR_MAX_CH-1:0] ch_priority,
    input wire logic [2*`DMR_MAX_CH-1:0] ch_mem_width,
    input wire logic [2*`DMR_MAX_CH-1:0] ch_periph_width
);
////////////////////////////////////////////////////////////
// write taken now, it commits on the next edge
logic wr_q;
always_ff @(posedge clk or negedge resetn)
begin
    if (!resetn)
        wr_q <= 1'b0;
    else
        wr_q <= hsel && htrans[1] && hready && hwrite;
end
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////
ok_resp_a: assert property (hresp == 1'b0) else $error("bus response not okay");
rd_stall_a: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read stall not exactly one cycle");
wr_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
irq_cause_a: assert property ($rose(ch_irq[0]) |-> $past(xfer_done[0] || xfer_error[0] || wr_q))
    else $error("irq rose without cause");
act_end_a: assert property ($fell(ch_active[0]) |-> $past(xfer_done[0] || wr_q))
    else $error("channel stopped without cause");
cfg_lock_a: assert property (ch_active[0] |=>
    $stable({ch_mem2mem[0], ch_dir[0], ch_priority[1:0], ch_mem_width[1:0], ch_periph_width[1:0]}))
    else $error("locked field changed");
mode_wr_a: assert property ($changed({ch_mem2mem, ch_dir, ch_priority}) |-> $past(wr_q))
    else $error("mode changed without write");
width_wr_a: assert property ($changed({ch_mem_width, ch_periph_width}) |-> $past(wr_q))
    else $error("width changed without write");
small_inst_a: assert property ((ch_active >> NUM_CH) == '0 && (ch_irq >> NUM_CH) == '0)
    else $error("absent channel active");
endmodule // dmr_regs_monitor

bind dmr_regs dmr_regs_monitor #(.NUM_CH(NUM_CH)) mon_u (.clk(clk), .resetn(resetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .xfer_done(xfer_done), .xfer_error(xfer_error), .ch_active(ch_active), .ch_irq(ch_irq),
    .ch_mem2mem(ch_mem2mem), .ch_dir(ch_dir), .ch_priority(ch_priority),
    .ch_mem_width(ch_mem_width), .ch_periph_width(ch_periph_width));

// [testbench/dmr_xfer_model.sv]
`timescale 1ns/1ps
// datapath side: one-cycle done or error pulses per channel
module dmr_xfer_model
(
    input wire logic clk,
    output logic [6:0] xfer_done,
    output logic [6:0] xfer_error
);
initial
begin
    xfer_done = '0;
    xfer_error = '0;
end
// gap lets the peripheral answer promptly or slowly
task automatic beat(input int ch, input bit err, input int gap);
    repeat (gap) @(posedge clk);
    if (err)
        xfer_error[ch] <= 1'b1;
    else
        xfer_done[ch] <= 1'b1;
    @(posedge clk);
    xfer_done <= '0;
    xfer_error <= '0;
    // idle edge, so a following beat never re-raises in this step
    @(posedge clk);
endtask
endmodule // dmr_xfer_model

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "dmr_params.svh"
module tb;
localparam logic [31:0] B0 = `DMR_BASE_FIRST;
localparam logic [31:0] B1 = `DMR_BASE_SECOND;
localparam logic [31:0] FLG = B0;
localparam logic [31:0] CLR = B0 + 32'h4;
logic clk, resetn, hsel, hwrite, hready, rdy1, rdy2, rdy_s;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] haddr, hwdata, rd1, rd2, rd_s, q, k;
logic [6:0] xfer_done, xfer_error, ch_active, ch_irq, ch_m2m, ch_dir;
logic [13:0] ch_priority_level, ch_mw, ch_pw;
logic [223:0] ch_maddr, ch_paddr;
int error_cnt = 0;
int checks_done = 0;
////////////////////////////////////////////////////////////
always #10 clk = ~clk;
// both windows share the bus; the one not addressed reads zero
assign hready = rdy1 & rdy2;
// sample answers mid-cycle, clear of the edge updates
always @(negedge clk)
begin
    rdy_s = hready;
    rd_s = rd1 | rd2;
end
dmr_regs dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(rd1),
    .hreadyout(rdy1), .hresp(), .xfer_done(xfer_done), .xfer_error(xfer_error),
    .ch_active(ch_active), .ch_irq(ch_irq), .ch_mem2mem(ch_m2m), .ch_dir(ch_dir),
    .ch_priority(ch_priority_level), .ch_mem_width(ch_mw), .ch_periph_width(ch_pw),
    .ch_mem_addr(ch_maddr), .ch_periph_addr(ch_paddr));
dmr_regs #(.NUM_CH(`DMR_SMALL_CH), .BASE_ADDR(B1)) dut2_u (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(rd2), .hreadyout(rdy2), .hresp(),
    .xfer_done(7'h00), .xfer_error(7'h00), .ch_active(), .ch_irq(), .ch_mem2mem(),
    .ch_dir(), .ch_priority(), .ch_mem_width(), .ch_periph_width(), .ch_mem_addr(),
    .ch_periph_addr());
dmr_xfer_model xm_u (.clk(clk), .xfer_done(xfer_done), .xfer_error(xfer_error));
////////////////////////////////////////////////////////////
function automatic logic [31:0] ctl(input logic [31:0] b, input int ch);
    return b + 32'h8 + 32'h14 * ch;
endfunction
// one single transfer; waits on hready at each phase
task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (rdy_s !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (rdy_s !== 1'b1) @(posedge clk);
    q = rd_s;
endtask
task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q, exp);
endtask
task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
// watchdog: the sequence needs about 150 cycles
initial
begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    close_out;
end
////////////////////////////////////////////////////////////
initial
begin
    clk = 0; resetn = 0; hsel = 1; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(FLG, 32'h0);
    rdc(CLR, 32'h0);
    rdc(ctl(B0, 6), 32'h0);
    rdc(B0 + 32'h3fc, 32'h0);
    // every code of priority and both widths
    for (int i = 0; i < 4; i++)
    begin
        k = i;
        wr(ctl(B0, 1), (k << 12) | (k << 10) | (k << 8));
        rdc(ctl(B0, 1), (k << 12) | (k << 10) | (k << 8));
        chk({30'h0, ch_priority_level[3:2]}, k);
        chk({30'h0, ch_mw[3:2]}, k);
        chk({30'h0, ch_pw[3:2]}, k);
    end
    wr(ctl(B0, 3), 32'hffff_fffe);
    rdc(ctl(B0, 3), 32'h0000_7ffe);
    chk({30'h0, ch_m2m[3], ch_dir[3]}, 32'h3);
    // one-shot run: 4 words, memory +4, peripheral fixed
    wr(ctl(B0, 0) + 32'h4, 32'h4);
    wr(ctl(B0, 0) + 32'hc, 32'h2000_0000);
    wr(ctl(B0, 0) + 32'h8, 32'h4000_0000);
    wr(ctl(B0, 0), 32'h0000_088f);
    wr(ctl(B0, 0), 32'h0000_7ff3);
    rdc(ctl(B0, 0), 32'h0000_0883);
    wr(ctl(B0, 0), 32'h0000_088f);
    wr(ctl(B0, 0) + 32'h4, 32'h9);
    rdc(ctl(B0, 0) + 32'h4, 32'h4);
    xm_u.beat(0, 0, 0);
    chk(ch_maddr[31:0], 32'h2000_0004);
    xm_u.beat(0, 0, 2);
    rdc(FLG, 32'h5);
    xm_u.beat(0, 0, 0);
    xm_u.beat(0, 0, 0);
    rdc(FLG, 32'h7);
    chk({31'h0, ch_irq[0]}, 32'h1);
    chk({31'h0, ch_active[0]}, 32'h0);
    chk(ch_paddr[31:0], 32'h4000_0000);
    xm_u.beat(0, 0, 0);
    chk(ch_maddr[31:0], 32'h2000_0010);
    wr(CLR, 32'h2);
    rdc(FLG, 32'h5);
    wr(CLR, 32'h0);
    wr(FLG, 32'hffff_ffff);
    rdc(FLG, 32'h5);
    xm_u.beat(0, 1, 0);
    rdc(FLG, 32'hd);
    wr(CLR, 32'h1);
    rdc(FLG, 32'h0);
    chk({31'h0, ch_irq[0]}, 32'h0);
    // circular run of 2: peripheral +2, memory +1, reload at the end
    wr(ctl(B0, 0), 32'h0);
    wr(ctl(B0, 0) + 32'h4, 32'h2);
    wr(ctl(B0, 0), 32'h0000_01e1);
    xm_u.beat(0, 0, 1);
    chk(ch_paddr[31:0], 32'h4000_0002);
    chk(ch_maddr[31:0], 32'h2000_0001);
    xm_u.beat(0, 0, 0);
    chk({31'h0, ch_active[0]}, 32'h1);
    chk(ch_maddr[31:0], 32'h2000_0000);
    rdc(ctl(B0, 0) + 32'h4, 32'h2);
    rdc(FLG, 32'h7);
    chk({31'h0, ch_irq[0]}, 32'h0);
    // second controller window
    wr(ctl(B1, 0), 32'h3000);
    rdc(ctl(B1, 0), 32'h3000);
    rdc(ctl(B0, 0), 32'h0000_01e1);
    wr(ctl(B1, 5), 32'h3000);
    rdc(ctl(B1, 5), 32'h0);
    rdc(B1, 32'h0);
    wr(ctl(B0, 5), 32'h3000);
    rdc(ctl(B0, 5), 32'h3000);
    close_out;
end
endmodule // tb
